/* verilog/rtc_channel_ctrl.sv */
// Two-channel retimer control: lock detect, adaptation, pattern, output mux, FIFO
// What this block does
// - Both channels run recovery, adaptation, pattern and output selection independently.
// - Output data is retimed with the recovered clean clock, cutting jitter.
// - Adaptation starts right after lock when a signal first appears.
// - Every clock-recovery reset restarts equalizer adaptation.
// - Adaptation steps boost, keeping the setting with best quality metric.
// - No improvement within look-ahead depth settles on the earlier lower boost.
// - Feedback equalizer tap weights and polarities adapt alongside boost.
// - Each channel generates its own 9-stage or 31-stage pseudo-random sequence.
// - Output source is raw, retimed, pattern, or other channel loopback.
// - Driver applies swing, de-emphasis, edge rate and polarity inversion.
// - Swing and de-emphasis live per channel in bus-writable registers.
// - Reference clock decides when the oscillator is frequency-locked, by counting its ticks.
// - Oscillator frequency is preset to one of few supported rates.
// - Edge-rate register bit 2 selects limited slew when one.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "rtc_params.svh"

module rtc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  cnt_q;
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic         wr;
	logic         rd;
	assign in_ready  = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign wr = in_valid & in_ready;
	assign rd = out_valid & out_ready;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			wp_q  <= '0;
			rp_q  <= '0;
		end else begin
			cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
			if (wr) begin
				wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
			end
			if (rd) begin
				rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (wr) begin
			mem[wp_q] <= in_data;
		end
	end
endmodule : rtc_fifo

module rtc_channel_ctrl import rtc_pkg::*; #(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	input  wire logic        ref_tick_in,
	input  wire logic [1:0]  osc_tick_in,
	input  wire logic [1:0]  sig_det_in,
	input  wire logic [15:0] metric_in,
	input  wire logic [9:0]  fb_err_in,
	input  wire logic [15:0] rx_raw_word,
	input  wire logic [15:0] rx_ret_word,
	input  wire logic [1:0]  rx_valid,
	input  wire logic [1:0]  tx_ready,
	output logic [15:0]      tx_word,
	output logic [1:0]       tx_valid,
	output logic [1:0]       lock_out,
	output logic [1:0]       cdr_rst_out,
	output logic [7:0]       boost_out,
	output logic [39:0]      taps_out,
	output logic [5:0]       swing_out,
	output logic [7:0]       deemph_out,
	output logic [1:0]       slew_limit_out,
	output logic [3:0]       osc_preset_out
);
	typedef struct packed {
		rtc_src_t    sel;
		logic        pol, p31, slew, cdr_rst, pend, lock, ovf, ov;
		logic [2:0]  swing;
		logic [3:0]  deemph;
		logic [1:0]  rate;
		logic        sd1, sd2, sd_prev, ot1, ot2, ot3;
		logic [7:0]  m1, m2;
		logic [4:0]  e1, e2;
		logic [15:0] oscn;
		rtc_adapt_t  st;
		logic [3:0]  boost, best_boost;
		logic [7:0]  best;
		logic [2:0]  miss;
		logic [6:0]  wait_n;
		logic [19:0] taps;
		logic [30:0] lfsr;
		logic [7:0]  ow;
	} rtc_ch_t;
	typedef struct packed {
		rtc_ch_t [1:0] ch;
		logic          r1, r2, r3;
		logic [15:0]   refn;
		logic [7:0]    rdata;
	} rtc_state_t;

	rtc_state_t s_q, s_d;
	logic [1:0]  push_v, push_r, pop, f_v;
	logic [15:0] push_w, f_w;
	logic        win_end;

	function automatic logic [15:0] rtc_expect(input logic [1:0] r);
		unique case (r)
			2'h0: rtc_expect = `RTC_EXP_R0;
			2'h1: rtc_expect = `RTC_EXP_R1;
			2'h2: rtc_expect = `RTC_EXP_R2;
			2'h3: rtc_expect = `RTC_EXP_R3;
		endcase
	endfunction : rtc_expect

	// Returns {word, next state}; eight bits per word
	function automatic logic [38:0] rtc_prbs(input logic [30:0] l, input logic p31);
		logic [7:0] w;
		logic       fb;
		w = '0;
		for (int b = 0; b < 8; b++) begin
			fb = p31 ? (l[30] ^ l[27]) : (l[8] ^ l[4]);
			l = {l[29:0], fb};
			if (!p31) begin
				l[30:9] = '0;
			end
			w[7-b] = fb;
		end
		rtc_prbs = {w, l};
	endfunction : rtc_prbs

	// ------------------------------------------------------------
	// Per-channel output FIFO
	// ------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_fifo
		rtc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
			.sys_clk   (sys_clk),
			.sys_rst   (sys_rst),
			.in_valid  (push_v[g]),
			.in_ready  (push_r[g]),
			.in_data   (push_w[g*8 +: 8]),
			.out_valid (f_v[g]),
			.out_ready (pop[g]),
			.out_data  (f_w[g*8 +: 8])
		);
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [38:0] pr;
		logic [15:0] dif;
		logic [7:0]  src;
		logic [2:0]  mn;
		logic        wsel, imp;
		logic [6:0]  a;
		logic [3:0]  t;
		pr = '0; dif = '0; src = '0; mn = '0; wsel = 1'b0; imp = 1'b0; a = '0; t = '0;
		s_d = s_q;
		push_v = '0;
		push_w = '0;
		pop = '0;
		a = reg_addr[6:0];
		s_d.r1 = ref_tick_in;
		s_d.r2 = s_q.r1;
		s_d.r3 = s_q.r2;
		win_end = 1'b0;
		if (s_q.r2 && !s_q.r3) begin
			win_end = (s_q.refn == `RTC_REF_WIN - 16'h0001);
			s_d.refn = win_end ? '0 : s_q.refn + 16'h0001;
		end
		s_d.rdata = '0;
		// Each channel is a full copy of the same logic; the reference window and read data are shared
		for (int i = 0; i < 2; i++) begin
			wsel = reg_wr && (reg_addr[7] == i[0]);
			s_d.ch[i].cdr_rst = 1'b0;
			s_d.ch[i].sd1 = sig_det_in[i];
			s_d.ch[i].sd2 = s_q.ch[i].sd1;
			s_d.ch[i].sd_prev = s_q.ch[i].sd2;
			s_d.ch[i].ot1 = osc_tick_in[i];
			s_d.ch[i].ot2 = s_q.ch[i].ot1;
			s_d.ch[i].ot3 = s_q.ch[i].ot2;
			s_d.ch[i].m1 = metric_in[i*8 +: 8];
			s_d.ch[i].m2 = s_q.ch[i].m1;
			s_d.ch[i].e1 = fb_err_in[i*5 +: 5];
			s_d.ch[i].e2 = s_q.ch[i].e1;
			if (wsel) begin
				unique case (a)
					`RTC_A_CTRL: begin
						s_d.ch[i].sel = rtc_src_t'(reg_wdata[1:0]);
						s_d.ch[i].pol = reg_wdata[`RTC_CTRL_POL];
						s_d.ch[i].p31 = reg_wdata[`RTC_CTRL_P31];
						s_d.ch[i].cdr_rst = reg_wdata[`RTC_CTRL_CDRRST];
					end
					`RTC_A_SWING:  s_d.ch[i].swing = reg_wdata[2:0];
					`RTC_A_DEEMPH: s_d.ch[i].deemph = reg_wdata[3:0];
					`RTC_A_RATE:   s_d.ch[i].rate = reg_wdata[1:0];
					`RTC_A_EDGE:   s_d.ch[i].slew = reg_wdata[`RTC_EDGE_SLEW];
					default: ;
				endcase
			end
			// Lock: oscillator ticks counted over a reference window
			if (s_q.ch[i].ot2 && !s_q.ch[i].ot3) begin
				s_d.ch[i].oscn = s_q.ch[i].oscn + 16'h0001;
			end
			if (win_end) begin
				dif = (s_q.ch[i].oscn > rtc_expect(s_q.ch[i].rate))
					? s_q.ch[i].oscn - rtc_expect(s_q.ch[i].rate)
					: rtc_expect(s_q.ch[i].rate) - s_q.ch[i].oscn;
				s_d.ch[i].lock = (dif <= `RTC_LOCK_TOL);
				s_d.ch[i].oscn = '0;
			end
			if (s_q.ch[i].sd2 && !s_q.ch[i].sd_prev) begin
				s_d.ch[i].pend = 1'b1;
			end
			if (s_q.ch[i].cdr_rst) begin
				s_d.ch[i].lock = 1'b0;
				s_d.ch[i].oscn = '0;
				s_d.ch[i].pend = 1'b1;
				s_d.ch[i].st = RTC_IDLE;
			end else begin
				unique case (s_q.ch[i].st)
					RTC_IDLE, RTC_DONE: begin
						if (s_q.ch[i].pend && s_q.ch[i].lock && s_q.ch[i].sd2) begin
							s_d.ch[i].pend = 1'b0;
							s_d.ch[i].boost = '0;
							s_d.ch[i].best = '0;
							s_d.ch[i].best_boost = '0;
							s_d.ch[i].miss = '0;
							s_d.ch[i].wait_n = 7'(`RTC_SETTLE_CYC);
							s_d.ch[i].st = RTC_SETTLE;
						end
					end
					RTC_SETTLE: begin
						s_d.ch[i].wait_n = s_q.ch[i].wait_n - 7'h01;
						if (s_q.ch[i].wait_n == 7'h01) begin
							s_d.ch[i].st = RTC_MEAS;
						end
					end
					RTC_MEAS: begin
						imp = s_q.ch[i].m2 > s_q.ch[i].best;
						mn = imp ? 3'h0 : s_q.ch[i].miss + 3'h1;
						s_d.ch[i].miss = mn;
						if (imp) begin
							s_d.ch[i].best = s_q.ch[i].m2;
							s_d.ch[i].best_boost = s_q.ch[i].boost;
						end
						// Sign-sign tap update, sign bit is tap polarity
						for (int k = 0; k < 5; k++) begin
							t = s_q.ch[i].taps[k*4 +: 4];
							if (s_q.ch[i].e2[k] && t != 4'h8) begin
								t = t - 4'h1;
							end else if (!s_q.ch[i].e2[k] && t != 4'h7) begin
								t = t + 4'h1;
							end
							s_d.ch[i].taps[k*4 +: 4] = t;
						end
						if (mn == `RTC_LOOKAHEAD || s_q.ch[i].boost == `RTC_BOOST_MAX) begin
							s_d.ch[i].boost = imp ? s_q.ch[i].boost
								: s_q.ch[i].best_boost;
							s_d.ch[i].st = RTC_DONE;
						end else begin
							s_d.ch[i].boost = s_q.ch[i].boost + 4'h1;
							s_d.ch[i].wait_n = 7'(`RTC_SETTLE_CYC);
							s_d.ch[i].st = RTC_SETTLE;
						end
					end
					default: s_d.ch[i].st = RTC_IDLE;
				endcase
			end
			pr = rtc_prbs(s_q.ch[i].lfsr, s_q.ch[i].p31);
			// Source mux; loopback takes the other channel's retimed word
			unique case (s_q.ch[i].sel)
				RTC_SRC_RAW:  src = rx_raw_word[i*8 +: 8];
				RTC_SRC_RET:  src = rx_ret_word[i*8 +: 8];
				RTC_SRC_PAT:  src = pr[38:31];
				RTC_SRC_LOOP: src = rx_ret_word[(1-i)*8 +: 8];
			endcase
			push_v[i] = (s_q.ch[i].sel == RTC_SRC_PAT) || rx_valid[i];
			push_w[i*8 +: 8] = s_q.ch[i].pol ? ~src : src;
			// Pattern stalls on a full FIFO; live data cannot, so it is flagged
			if (s_q.ch[i].sel == RTC_SRC_PAT && push_r[i]) begin
				// Whole state: long runs of zeros are legal in the 31-stage sequence
				s_d.ch[i].lfsr = (pr[30:0] == 31'h0) ? `RTC_SEED : pr[30:0];
			end
			if (wsel && a == `RTC_A_STAT && reg_wdata[`RTC_STAT_OVF]) begin
				s_d.ch[i].ovf = 1'b0;
			end
			if (push_v[i] && !push_r[i] && s_q.ch[i].sel != RTC_SRC_PAT) begin
				s_d.ch[i].ovf = 1'b1;
			end
			pop[i] = f_v[i] && (!s_q.ch[i].ov || tx_ready[i]);
			if (pop[i]) begin
				s_d.ch[i].ow = f_w[i*8 +: 8];
				s_d.ch[i].ov = 1'b1;
			end else if (tx_ready[i]) begin
				s_d.ch[i].ov = 1'b0;
			end
			if (reg_rd && reg_addr[7] == i[0]) begin
				unique case (a)
					`RTC_A_CTRL:   s_d.rdata = {4'h0, s_q.ch[i].p31, s_q.ch[i].pol,
						s_q.ch[i].sel};
					`RTC_A_SWING:  s_d.rdata = {5'h00, s_q.ch[i].swing};
					`RTC_A_DEEMPH: s_d.rdata = {4'h0, s_q.ch[i].deemph};
					`RTC_A_RATE:   s_d.rdata = {6'h00, s_q.ch[i].rate};
					`RTC_A_STAT:   s_d.rdata = {3'h0, s_q.ch[i].ovf, s_q.ch[i].st == RTC_DONE,
						s_q.ch[i].st != RTC_IDLE && s_q.ch[i].st != RTC_DONE,
						s_q.ch[i].sd2, s_q.ch[i].lock};
					`RTC_A_BOOST:  s_d.rdata = {4'h0, s_q.ch[i].boost};
					`RTC_A_TAPS:   s_d.rdata = {3'h0, s_q.ch[i].taps[19], s_q.ch[i].taps[15],
						s_q.ch[i].taps[11], s_q.ch[i].taps[7], s_q.ch[i].taps[3]};
					`RTC_A_EDGE:   s_d.rdata = {5'h00, s_q.ch[i].slew, 2'h0};
					default:       s_d.rdata = '0;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.ch[0].lfsr <= `RTC_SEED;
			s_q.ch[1].lfsr <= `RTC_SEED;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata = s_q.rdata;
	for (genvar o = 0; o < 2; o++) begin : g_out
		assign tx_word[o*8 +: 8]      = s_q.ch[o].ow;
		assign tx_valid[o]            = s_q.ch[o].ov;
		assign lock_out[o]            = s_q.ch[o].lock;
		assign cdr_rst_out[o]         = s_q.ch[o].cdr_rst;
		assign boost_out[o*4 +: 4]    = s_q.ch[o].boost;
		assign taps_out[o*20 +: 20]   = s_q.ch[o].taps;
		assign swing_out[o*3 +: 3]    = s_q.ch[o].swing;
		assign deemph_out[o*4 +: 4]   = s_q.ch[o].deemph;
		assign slew_limit_out[o]      = s_q.ch[o].slew;
		assign osc_preset_out[o*2 +: 2] = s_q.ch[o].rate;
	end

	// ------------------------------------------------------------
	// Assertions, channel 0
	// ------------------------------------------------------------
	property p_lock_window;
		@(posedge sys_clk) disable iff (sys_rst) $rose(s_q.ch[0].lock) |-> $past(win_end);
	endproperty
	a_lock_window: assert property (p_lock_window) else $error("lock rose off window");
	property p_adapt_start;
		@(posedge sys_clk) disable iff (sys_rst)
			s_q.ch[0].st == RTC_IDLE && s_q.ch[0].pend && s_q.ch[0].lock && s_q.ch[0].sd2
			&& !s_q.ch[0].cdr_rst |=> s_q.ch[0].st == RTC_SETTLE && s_q.ch[0].boost == 4'h0;
	endproperty
	a_adapt_start: assert property (p_adapt_start) else $error("adaptation did not start");
	property p_cdr_restart;
		@(posedge sys_clk) disable iff (sys_rst)
			s_q.ch[0].cdr_rst |=> !s_q.ch[0].lock && s_q.ch[0].pend && s_q.ch[0].st == RTC_IDLE;
	endproperty
	a_cdr_restart: assert property (p_cdr_restart) else $error("reset did not rearm");
	property p_settle_low;
		@(posedge sys_clk) disable iff (sys_rst)
			s_q.ch[0].st == RTC_MEAS && s_q.ch[0].miss == 3'h2 && s_q.ch[0].m2 <= s_q.ch[0].best
			&& !s_q.ch[0].cdr_rst |=> s_q.ch[0].st == RTC_DONE
			&& s_q.ch[0].boost == $past(s_q.ch[0].best_boost);
	endproperty
	a_settle_low: assert property (p_settle_low) else $error("did not settle lower");
	property p_step;
		@(posedge sys_clk) disable iff (sys_rst)
			s_q.ch[0].st == RTC_SETTLE && !s_q.ch[0].cdr_rst && !reg_wr
			|=> $stable(s_q.ch[0].boost);
	endproperty
	a_step: assert property (p_step) else $error("boost moved while settling");
	property p_no_zero;
		@(posedge sys_clk) disable iff (sys_rst) s_q.ch[0].lfsr != 31'h0;
	endproperty
	a_no_zero: assert property (p_no_zero) else $error("pattern state zero");
	property p_mux_ret;
		@(posedge sys_clk) disable iff (sys_rst)
			s_q.ch[0].sel == RTC_SRC_RET |-> push_w[7:0] == (rx_ret_word[7:0] ^ {8{s_q.ch[0].pol}});
	endproperty
	a_mux_ret: assert property (p_mux_ret) else $error("wrong retimed source");
	property p_swing_wr;
		@(posedge sys_clk) disable iff (sys_rst)
			reg_wr && reg_addr == {1'b0, `RTC_A_SWING} |=> ##1 swing_out[2:0] == $past(reg_wdata[2:0], 2);
	endproperty
	a_swing_wr: assert property (p_swing_wr) else $error("swing not written");
	property p_slew;
		@(posedge sys_clk) disable iff (sys_rst)
			reg_wr && reg_addr == {1'b0, `RTC_A_EDGE} |=> slew_limit_out[0] == $past(reg_wdata[2]);
	endproperty
	a_slew: assert property (p_slew) else $error("slew bit wrong");
	c_lock:  cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(s_q.ch[0].lock));
	c_done:  cover property (@(posedge sys_clk) disable iff (sys_rst) s_q.ch[0].st == RTC_DONE);
	c_full:  cover property (@(posedge sys_clk) disable iff (sys_rst) !push_r[0]);
endmodule : rtc_channel_ctrl

/* verilog/rtc_params.svh */
// Register offsets, field positions and timing counts for the retimer channel control
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define RTC_A_CTRL      7'h01
`define RTC_A_SWING     7'h02
`define RTC_A_DEEMPH    7'h03
`define RTC_A_RATE      7'h04
`define RTC_A_STAT      7'h05
`define RTC_A_BOOST     7'h06
`define RTC_A_TAPS      7'h07
`define RTC_A_EDGE      7'h18
`define RTC_EDGE_SLEW   2
`define RTC_CTRL_POL    2
`define RTC_CTRL_P31    3
`define RTC_CTRL_CDRRST 4
`define RTC_STAT_OVF    4
`define RTC_REF_WIN     16'h0040
`define RTC_LOCK_TOL    16'h0004
`define RTC_EXP_R0      16'h0064
`define RTC_EXP_R1      16'h00c8
`define RTC_EXP_R2      16'h0190
`define RTC_EXP_R3      16'h0320
`define RTC_CLK_NS      20
`define RTC_SETTLE_NS   1000
`define RTC_SETTLE_CYC  ((`RTC_SETTLE_NS + `RTC_CLK_NS - 1) / `RTC_CLK_NS)
`define RTC_LOOKAHEAD   3'h3
`define RTC_BOOST_MAX   4'hf
`define RTC_SEED        31'h7fffffff
`endif

/* verilog/rtc_pkg.sv */
// Types shared by the retimer channel control
package rtc_pkg;
	typedef enum logic [2:0] {
		RTC_IDLE   = 3'h0,
		RTC_SETTLE = 3'h1,
		RTC_MEAS   = 3'h3,
		RTC_DONE   = 3'h2
	} rtc_adapt_t;
	typedef enum logic [1:0] {
		RTC_SRC_RAW  = 2'h0,
		RTC_SRC_RET  = 2'h1,
		RTC_SRC_PAT  = 2'h2,
		RTC_SRC_LOOP = 2'h3
	} rtc_src_t;
endpackage : rtc_pkg

/* verif/rtc_far_model.sv */
// Far-side model: reference and oscillator ticks, line source, line sink
`timescale 1ns/100ps
module rtc_far_model #(
	parameter int REF_HALF = 25,
	parameter int PEAK0    = 5,
	parameter int PEAK1    = 20
) (
	input  wire logic        sys_clk,
	input  wire logic [1:0]  sig_on,
	input  wire logic [1:0]  off_freq,
	input  wire logic [1:0]  stall,
	input  wire logic [7:0]  boost_out,
	input  wire logic [3:0]  osc_preset_out,
	input  wire logic [15:0] tx_word,
	input  wire logic [1:0]  tx_valid,
	output logic             ref_tick_in,
	output logic [1:0]       osc_tick_in,
	output logic [1:0]       sig_det_in,
	output logic [15:0]      metric_in,
	output logic [9:0]       fb_err_in,
	output logic [15:0]      rx_raw_word,
	output logic [15:0]      rx_ret_word,
	output logic [1:0]       rx_valid,
	output logic [1:0]       tx_ready
);
	logic [7:0] got0[$];
	logic [7:0] got1[$];
	int         ref_cnt = 0;
	int         osc_cnt[2] = '{0, 0};

	// Single peak, no dip on the way up, so adaptation never stops early
	function automatic logic [7:0] quality(input logic [3:0] b, input int peak);
		int d;
		d = (int'(b) > peak) ? int'(b) - peak : peak - int'(b);
		return 8'hff - 8'(d * 8);
	endfunction : quality

	// Exact expected count per 64-tick window at each preset
	function automatic int osc_half(input logic [1:0] rate, input logic off);
		return off ? 18 : 16 >> rate;
	endfunction : osc_half

	task automatic send(input logic [1:0] mask, input logic [15:0] raw, input logic [15:0] ret);
		@(posedge sys_clk);
		rx_valid    <= mask;
		rx_raw_word <= raw;
		rx_ret_word <= ret;
		@(posedge sys_clk);
		rx_valid    <= 2'b00;
		rx_raw_word <= ~raw;
		rx_ret_word <= ~ret;
	endtask : send

	initial begin
		ref_tick_in = 1'b0;
		osc_tick_in = 2'b00;
		sig_det_in  = 2'b00;
		metric_in   = 16'h0000;
		fb_err_in   = 10'h01f;
		rx_raw_word = 16'h0000;
		rx_ret_word = 16'h0000;
		rx_valid    = 2'b00;
		tx_ready    = 2'b11;
	end

	always @(posedge sys_clk) begin
		ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
		if (ref_cnt == REF_HALF - 1) begin
			ref_tick_in <= ~ref_tick_in;
		end
		for (int c = 0; c < 2; c++) begin
			if (osc_cnt[c] >= osc_half(osc_preset_out[2*c+:2], off_freq[c]) - 1) begin
				osc_cnt[c]     <= 0;
				osc_tick_in[c] <= ~osc_tick_in[c];
			end else begin
				osc_cnt[c] <= osc_cnt[c] + 1;
			end
		end
		sig_det_in <= sig_on;
		metric_in  <= {quality(boost_out[7:4], PEAK1), quality(boost_out[3:0], PEAK0)};
		tx_ready   <= ~stall;
		if (tx_valid[0] && tx_ready[0]) begin
			got0.push_back(tx_word[7:0]);
		end
		if (tx_valid[1] && tx_ready[1]) begin
			got1.push_back(tx_word[15:8]);
		end
	end
endmodule : rtc_far_model

/* verif/testbench.sv */
// Self-checking bench for the retimer channel control
`timescale 1ns/100ps
`include "rtc_params.svh"
module testbench;
	logic        sys_clk, sys_rst, reg_wr, reg_rd, ref_tick_in;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, boost_out, deemph_out;
	logic [1:0]  osc_tick_in, sig_det_in, rx_valid, tx_ready, tx_valid;
	logic [1:0]  lock_out, cdr_rst_out, slew_limit_out;
	logic [15:0] metric_in, rx_raw_word, rx_ret_word, tx_word;
	logic [9:0]  fb_err_in;
	logic [39:0] taps_out;
	logic [5:0]  swing_out;
	logic [3:0]  osc_preset_out;
	logic [1:0]  sig_on = 2'b00, off_freq = 2'b00, stall = 2'b00;
	logic [7:0]  d;
	int          err_total = 0, total_checks = 0, n;
	logic [6:0]  offs[7] = '{`RTC_A_CTRL, `RTC_A_SWING, `RTC_A_DEEMPH, `RTC_A_RATE,
		`RTC_A_BOOST, `RTC_A_TAPS, `RTC_A_EDGE};
	logic [7:0]  ctrl_tab[4] = '{8'h00, 8'h01, 8'h05, 8'h03};
	logic [7:0]  exp_tab[4] = '{8'h3c, 8'hc5, 8'h3a, 8'h96};

	rtc_channel_ctrl #(.FIFO_DEPTH(8)) dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .ref_tick_in, .osc_tick_in, .sig_det_in, .metric_in, .fb_err_in,
		.rx_raw_word, .rx_ret_word, .rx_valid, .tx_ready, .tx_word, .tx_valid, .lock_out,
		.cdr_rst_out, .boost_out, .taps_out, .swing_out, .deemph_out, .slew_limit_out,
		.osc_preset_out);
	rtc_far_model far (.sys_clk, .sig_on, .off_freq, .stall, .boost_out, .osc_preset_out,
		.tx_word, .tx_valid, .ref_tick_in, .osc_tick_in, .sig_det_in, .metric_in, .fb_err_in,
		.rx_raw_word, .rx_ret_word, .rx_valid, .tx_ready);

	// --------------------------------------------------------------
	// Bus tasks and checks
	// --------------------------------------------------------------
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic ch, input logic [6:0] off, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= {ch, off};
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic ch, input logic [6:0] off, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= {ch, off};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
	endtask : rd

	task automatic rchk(input logic ch, input logic [6:0] off, input logic [7:0] e);
		logic [7:0] v;
		rd(ch, off, v);
		chk(v, e, "register read");
	endtask : rchk

	// Bounded poll of one status bit
	task automatic wait_bit(input logic ch, input int b);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 4000 && v[b] !== 1'b1; i++) begin
			rd(ch, `RTC_A_STAT, v);
		end
		chk(40'(v[b]), 40'd1, "status poll");
	endtask : wait_bit

	// Stall right after the pattern starts so it must pause without losing bits
	task automatic run_pat(input logic [7:0] ctrl, input int len, input int tap);
		logic bits[$];
		int   bad;
		int   ones;
		bad  = 0;
		ones = 0;
		far.got0.delete();
		wr(1'b0, `RTC_A_CTRL, ctrl);
		stall <= 2'b01;
		repeat (30) @(posedge sys_clk);
		stall <= 2'b00;
		repeat (30) @(posedge sys_clk);
		wr(1'b0, `RTC_A_CTRL, 8'h00);
		repeat (20) @(posedge sys_clk);
		foreach (far.got0[i]) begin
			for (int k = 7; k >= 0; k--) begin
				bits.push_back(far.got0[i][k]);
			end
		end
		for (int i = len; i < bits.size(); i++) begin
			bad  += (bits[i] !== (bits[i-len] ^ bits[i-tap])) ? 1 : 0;
			ones += (bits[i] === 1'b1) ? 1 : 0;
		end
		chk(40'(bad), 40'd0, "sequence feedback");
		chk(40'(ones > 0 && bits.size() > 100), 40'd1, "sequence length");
	endtask : run_pat

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (80000) @(posedge sys_clk);
		err_total++;
		$display("wrong value at %0t: run timed out", $time);
		wrap_up();
	end

	// --------------------------------------------------------------
	// Test sequence
	// --------------------------------------------------------------
	initial begin
		sys_rst   = 1'b1;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int c = 0; c < 2; c++) begin
			foreach (offs[i]) begin
				rchk(c[0], offs[i], 8'h00);
			end
		end
		wr(1'b0, `RTC_A_SWING, 8'hff);
		wr(1'b1, `RTC_A_SWING, 8'h05);
		wr(1'b0, `RTC_A_DEEMPH, 8'h0a);
		wr(1'b1, `RTC_A_DEEMPH, 8'hf3);
		wr(1'b0, `RTC_A_EDGE, 8'h04);
		wr(1'b1, `RTC_A_EDGE, 8'hfb);
		wr(1'b0, 7'h7f, 8'hff);
		wr(1'b0, `RTC_A_BOOST, 8'hff);
		rchk(1'b0, `RTC_A_SWING, 8'h07);
		rchk(1'b1, `RTC_A_DEEMPH, 8'h03);
		rchk(1'b0, `RTC_A_EDGE, 8'h04);
		rchk(1'b1, `RTC_A_EDGE, 8'h00);
		rchk(1'b0, 7'h7f, 8'h00);
		rchk(1'b0, `RTC_A_BOOST, 8'h00);
		chk({swing_out, deemph_out, slew_limit_out}, {6'h2f, 8'h3a, 2'h1}, "driver");
		sig_on <= 2'b01;
		wait_bit(1'b0, 3);
		rchk(1'b0, `RTC_A_STAT, 8'h0b);
		rchk(1'b1, `RTC_A_STAT, 8'h01);
		chk(boost_out, 8'h05, "boost settles at peak");
		chk(taps_out[19:0], 20'h88888, "taps ch0");
		rchk(1'b0, `RTC_A_TAPS, 8'h1f);
		chk(lock_out, 2'b11, "both locked");
		sig_on <= 2'b11;
		wait_bit(1'b1, 3);
		chk(boost_out, 8'hf5, "boost climbs to top");
		chk(taps_out[39:20], 20'h77777, "taps ch1");
		wr(1'b0, `RTC_A_CTRL, 8'h10);
		n = 0;
		repeat (4) begin
			@(negedge sys_clk);
			n += (cdr_rst_out === 2'b01) ? 1 : 0;
		end
		chk(40'(n), 40'd1, "recovery reset pulse");
		chk({lock_out, boost_out[7:4]}, 6'h2f, "other channel kept");
		wait_bit(1'b0, 2);
		wait_bit(1'b0, 3);
		chk(boost_out[3:0], 4'h5, "boost after restart");
		rchk(1'b0, `RTC_A_CTRL, 8'h00);
		for (int r = 1; r < 5; r++) begin
			wr(1'b0, `RTC_A_RATE, 8'(r % 4));
			repeat (7000) @(posedge sys_clk);
			@(negedge sys_clk);
			chk({osc_preset_out[1:0], lock_out[0]}, {2'(r % 4), 1'b1}, "rate lock");
		end
		off_freq <= 2'b01;
		repeat (7000) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(lock_out, 2'b10, "lock lost off frequency");
		off_freq <= 2'b00;
		foreach (ctrl_tab[i]) begin
			wr(1'b0, `RTC_A_CTRL, ctrl_tab[i]);
			far.got0.delete();
			far.got1.delete();
			far.send(2'b11, 16'h693c, 16'h96c5);
			repeat (10) @(posedge sys_clk);
			chk({far.got0[0], far.got1[0], 8'(far.got0.size())}, {exp_tab[i], 16'h6901},
				"source");
		end
		wr(1'b0, `RTC_A_CTRL, 8'h00);
		stall <= 2'b01;
		far.got0.delete();
		for (int i = 0; i < 12; i++) begin
			far.send(2'b01, {8'h00, 8'(8'h10 + i)}, 16'h0000);
		end
		rd(1'b0, `RTC_A_STAT, d);
		chk(d[4], 1'b1, "overflow flag");
		stall <= 2'b00;
		repeat (30) @(posedge sys_clk);
		n = far.got0.size();
		chk(40'(n >= 8 && n <= 10), 40'd1, "buffer depth");
		foreach (far.got0[i]) begin
			chk(far.got0[i], 8'(8'h10 + i), "buffer order");
		end
		wr(1'b0, `RTC_A_STAT, 8'h10);
		rd(1'b0, `RTC_A_STAT, d);
		chk(d[4], 1'b0, "overflow cleared");
		run_pat(8'h02, 9, 5);
		run_pat(8'h0a, 31, 28);
		wrap_up();
	end
endmodule : testbench
